//--- include/ivp_pkg.sv
// package: constants, register map and carrier types for the vector/priority map
package ivp_pkg;
  localparam int IVP_NSRC = 8;            // on-chip sources handled here
  localparam int IVP_NETH = 19;           // ethernet dma status sources
  localparam int IVP_NLINK = 3;           // link-controller status bits
  localparam logic [6:0] IVP_VEC_NMI = 7'h0b;
  localparam logic [6:0] IVP_VEC_BRK = 7'h0c;
  localparam logic [6:0] IVP_VEC_DBG = 7'h0d;
  localparam logic [6:0] IVP_VEC_PIN0 = 7'h40;
  localparam logic [4:0] IVP_LVL_NMI = 5'h10;
  localparam logic [4:0] IVP_LVL_FIX = 5'h0f;
  localparam int IVP_VEC_SCALE = 2;       // table entry = base + vector*4
  // register byte offsets
  localparam logic [5:0] IVP_A_CTRL = 6'h00;
  localparam logic [5:0] IVP_A_PRIA = 6'h04;
  localparam logic [5:0] IVP_A_PRIB = 6'h08;
  localparam logic [5:0] IVP_A_VECA = 6'h0c;
  localparam logic [5:0] IVP_A_VECB = 6'h10;
  localparam logic [5:0] IVP_A_VBASE = 6'h14;
  localparam logic [5:0] IVP_A_ETHST = 6'h18;
  localparam logic [5:0] IVP_A_ETHEN = 6'h1c;
  localparam logic [5:0] IVP_A_ISTAT = 6'h20;
  localparam logic [5:0] IVP_A_IMASK = 6'h24;
  localparam logic [5:0] IVP_A_RSVB = 6'h28;
  localparam logic [5:0] IVP_A_ACK = 6'h2c;
  localparam int IVP_CTRL_MODE = 0;       // 1: four pin mode, 0: encoded
  localparam int IVP_CTRL_COPY = 1;       // merge link bits into copy flag
  localparam int IVP_ETH_COPY = 19;       // copy flag position
  localparam logic [31:0] IVP_RSV_READ = 32'h0000_0000;

  typedef struct packed {
    logic       valid;
    logic [3:0] level;
    logic [6:0] vector;
    logic [31:0] entry;
  } ivp_req_s;

  typedef struct packed {
    logic [5:0] address;
    logic       read;
    logic       write;
    logic [31:0] writedata;
  } ivp_bus_s;
endpackage : ivp_pkg

//--- hdl/ivp_arbiter.sv
// priority arbiter: picks the highest level among 16 candidates
`timescale 1ns/1ps
module ivp_arbiter #(
  parameter int N = 16
) (
  input wire logic [N-1:0] req,      // candidate requesting
  input wire logic [N*5-1:0] lvl,    // 5-bit level per candidate
  input wire logic [N*7-1:0] vec,    // vector per candidate
  output logic win,                  // some candidate won
  output logic [4:0] win_lvl,        // winning level
  output logic [6:0] win_vec         // winning vector
);
  // lower index wins ties: that is the fixed default order
  always_comb begin
    win = 1'b0;
    win_lvl = 5'h00;
    win_vec = 7'h00;
    for (int i = 0; i < N; i++) begin
      if (req[i] && lvl[i*5 +: 5] != 5'h00 &&
          (!win || lvl[i*5 +: 5] > win_lvl)) begin
        win = 1'b1;
        win_lvl = lvl[i*5 +: 5];
        win_vec = vec[i*7 +: 7];
      end
    end
  end
endmodule : ivp_arbiter

//--- hdl/ivp_top.sv
// top: interrupt vector and priority map with avalon register slave
//
// Contract
// - accepted external request may take a 0..127 vector from outside.
// - each on-chip source takes a 7-bit vector from bits 14-8 or 6-0.
// - control mode bit picks encoded fifteen levels or four pin inputs.
// - ethernet request is OR of nineteen enabled status sources.
// - three link bits merge to a copy flag, up to 22 sources.
// - pin mode: nmi 11 at 16, break 12/debug 13 at 15, pins 64-67.
// - table entry address is vector base plus four times vector.
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module ivp_top #(
  parameter int NSRC = ivp_pkg::IVP_NSRC
) (
  input wire logic CLOCK,                 // 100 MHz clock
  input wire logic RST,                   // sync reset, active high
  input wire logic CE,                    // clock enable
  input wire logic [5:0] AVS_ADDRESS,     // byte address
  input wire logic AVS_READ,              // read strobe
  input wire logic AVS_WRITE,             // write strobe
  input wire logic [31:0] AVS_WRITEDATA,  // write data
  input wire logic [3:0] AVS_BYTEENABLE,  // byte lanes
  output logic [31:0] AVS_READDATA,       // read data
  output logic AVS_WAITREQUEST,           // stall
  input wire logic NMI_IN,                // non-maskable request
  input wire logic BRK_IN,                // user break request
  input wire logic DBG_IN,                // debug_interface request
  input wire logic [3:0] PIN_REQ,         // request pins / encoded levels
  input wire logic EXT_VEC_EN,            // take vector from outside
  input wire logic [6:0] EXT_VEC,         // external vector
  input wire logic [NSRC-1:0] SRC_REQ,    // on-chip source requests
  input wire logic [ivp_pkg::IVP_NETH-1:0] ETH_EVT, // ethernet status events
  input wire logic [ivp_pkg::IVP_NLINK-1:0] LINK_EVT, // link status events
  output logic REQ_VALID,                 // request to cpu
  output logic [4:0] REQ_LEVEL,           // its level
  output logic [6:0] REQ_VECTOR,          // its vector
  output logic [31:0] REQ_ENTRY,          // table entry address
  output logic ETH_IRQ,                   // ethernet_dma_event
  output logic IRQ                        // status interrupt
);
  import ivp_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_r, pria_r, prib_r, veca_r, vecb_r, vbase_r;
  logic [IVP_NETH:0] eth_st_r;
  logic [IVP_NETH:0] eth_en_r;
  logic [1:0] istat_r, imask_r;
  logic [31:0] rdata_r;
  logic rd_done_r;
  logic wr, rd;
  logic eth_irq_nxt, link_any;
  logic win;
  logic [4:0] win_lvl;
  logic [6:0] win_vec;
  logic [15:0] c_req;
  logic [79:0] c_lvl;
  logic [111:0] c_vec;
  logic ack_hit;

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // 7-bit vector field: odd sources sit in bits 6-0, even in 14-8
  function automatic logic [6:0] vfield(input logic [31:0] reg_v,
                                        input logic hi);
    return hi ? reg_v[14:8] : reg_v[6:0];
  endfunction : vfield

  ////////////////////////////////////////////////////////////////////////
  // reads take one wait cycle so the data can come from a flop;
  // a write is stalled while frozen, else it would be lost unseen
  assign wr = CE && AVS_WRITE;
  assign rd = CE && AVS_READ && !rd_done_r;
  assign AVS_WAITREQUEST = (AVS_WRITE && !CE) || (AVS_READ && !rd_done_r);
  assign AVS_READDATA = rdata_r;
  assign ack_hit = wr && AVS_ADDRESS == IVP_A_ACK;

  // configuration registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl_r <= 32'h0;
      pria_r <= 32'h0;
      prib_r <= 32'h0;
      veca_r <= 32'h0;
      vecb_r <= 32'h0;
      vbase_r <= 32'h0;
      eth_en_r <= '0;
      imask_r <= 2'h0;
    end else if (wr) begin
      unique case (AVS_ADDRESS)
        IVP_A_CTRL: ctrl_r <= merge(ctrl_r, AVS_WRITEDATA, AVS_BYTEENABLE);
        IVP_A_PRIA: pria_r <= merge(pria_r, AVS_WRITEDATA, AVS_BYTEENABLE);
        IVP_A_PRIB: prib_r <= merge(prib_r, AVS_WRITEDATA, AVS_BYTEENABLE);
        IVP_A_VECA: veca_r <= merge(veca_r, AVS_WRITEDATA, AVS_BYTEENABLE);
        IVP_A_VECB: vecb_r <= merge(vecb_r, AVS_WRITEDATA, AVS_BYTEENABLE);
        IVP_A_VBASE: vbase_r <= merge(vbase_r, AVS_WRITEDATA,
                                      AVS_BYTEENABLE);
        IVP_A_ETHEN: eth_en_r <= AVS_WRITEDATA[IVP_NETH:0];
        IVP_A_IMASK: imask_r <= AVS_WRITEDATA[1:0];
        default: ; // reserved slot and unmapped writes are dropped
      endcase
    end
  end

  // read data and one-cycle read handshake
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_r <= 32'h0;
      rd_done_r <= 1'b0;
    end else if (CE) begin
      rd_done_r <= rd;
      if (rd) begin
        unique case (AVS_ADDRESS)
          IVP_A_CTRL: rdata_r <= ctrl_r;
          IVP_A_PRIA: rdata_r <= pria_r;
          IVP_A_PRIB: rdata_r <= prib_r;
          IVP_A_VECA: rdata_r <= veca_r;
          IVP_A_VECB: rdata_r <= vecb_r;
          IVP_A_VBASE: rdata_r <= vbase_r;
          IVP_A_ETHST: rdata_r <= 32'(eth_st_r);
          IVP_A_ETHEN: rdata_r <= 32'(eth_en_r);
          IVP_A_ISTAT: rdata_r <= {30'h0, istat_r};
          IVP_A_IMASK: rdata_r <= {30'h0, imask_r};
          IVP_A_RSVB: rdata_r <= IVP_RSV_READ;
          default: rdata_r <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ethernet status: sticky, write-one-to-clear, set wins over clear
  assign link_any = ctrl_r[IVP_CTRL_COPY] && (|LINK_EVT);
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      eth_st_r <= '0;
    end else if (CE) begin
      eth_st_r <= (eth_st_r & ~((wr && AVS_ADDRESS == IVP_A_ETHST) ?
                   AVS_WRITEDATA[IVP_NETH:0] : '0))
                  | {link_any, ETH_EVT};
    end
  end
  assign eth_irq_nxt = |(eth_st_r & eth_en_r);
  assign ETH_IRQ = eth_irq_nxt;

  ////////////////////////////////////////////////////////////////////////
  // candidate table: fixed sources, pins, on-chip sources, ethernet
  always_comb begin
    c_req = '0;
    c_lvl = '0;
    c_vec = '0;
    c_req[0] = NMI_IN;
    c_lvl[4:0] = IVP_LVL_NMI;
    c_vec[6:0] = IVP_VEC_NMI;
    c_req[1] = BRK_IN;
    c_lvl[9:5] = IVP_LVL_FIX;
    c_vec[13:7] = IVP_VEC_BRK;
    c_req[2] = DBG_IN;
    c_lvl[14:10] = IVP_LVL_FIX;
    c_vec[20:14] = IVP_VEC_DBG;
    if (ctrl_r[IVP_CTRL_MODE]) begin
      for (int p = 0; p < 4; p++) begin
        c_req[3+p] = PIN_REQ[p];
        c_lvl[(3+p)*5 +: 5] = {1'b0, pria_r[(3-p)*4 +: 4]};
        c_vec[(3+p)*7 +: 7] = EXT_VEC_EN ? EXT_VEC :
                              IVP_VEC_PIN0 + 7'(p);
      end
    end else begin
      // encoded: level is the pin value itself, auto-vector 64 + level/2
      c_req[3] = PIN_REQ != 4'h0;
      c_lvl[19:15] = {1'b0, PIN_REQ};
      c_vec[27:21] = EXT_VEC_EN ? EXT_VEC :
                     IVP_VEC_PIN0 + 7'(PIN_REQ[3:1]);
    end
    for (int s = 0; s < NSRC; s++) begin
      c_req[7+s] = SRC_REQ[s];
      c_lvl[(7+s)*5 +: 5] = {1'b0, prib_r[(s/2)*4 +: 4]};
      c_vec[(7+s)*7 +: 7] = vfield(s < 4 ? veca_r : vecb_r,
                                   !s[0] ^ (s >= 4 && 1'b0));
    end
    c_req[15] = eth_irq_nxt;
    c_lvl[79:75] = {1'b0, prib_r[31:28]};
    c_vec[111:105] = veca_r[30:24];
  end

  ivp_arbiter #(.N(16)) u_arb (
    .req(c_req),
    .lvl(c_lvl),
    .vec(c_vec),
    .win(win),
    .win_lvl(win_lvl),
    .win_vec(win_vec)
  );

  // registered request to the cpu with table entry address
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      REQ_VALID <= 1'b0;
      REQ_LEVEL <= 5'h00;
      REQ_VECTOR <= 7'h00;
      REQ_ENTRY <= 32'h0;
    end else if (CE) begin
      REQ_VALID <= win;
      REQ_LEVEL <= win_lvl;
      REQ_VECTOR <= win_vec;
      REQ_ENTRY <= vbase_r + (32'(win_vec) << IVP_VEC_SCALE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status: bit0 request taken by cpu (ack write), bit1 ethernet event;
  // read clears, a new event in the same cycle wins
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      istat_r <= 2'h0;
    end else if (CE) begin
      istat_r <= ((rd && AVS_ADDRESS == IVP_A_ISTAT) ? 2'h0 : istat_r)
                 | {eth_irq_nxt, ack_hit && REQ_VALID};
    end
  end
  assign IRQ = |(istat_r & imask_r);
endmodule : ivp_top

//--- sim/ivp_top_properties.sv
// checker: mapping and bus timing properties of the vector/priority map
`timescale 1ns/1ps
module ivp_top_properties #(
  parameter int NSRC = ivp_pkg::IVP_NSRC
) (
  input wire logic CLOCK, // clock
  input wire logic RST, // sync reset
  input wire logic CE, // clock enable
  input wire logic [5:0] AVS_ADDRESS, // byte address
  input wire logic AVS_READ, // read strobe
  input wire logic AVS_WRITE, // write strobe
  input wire logic AVS_WAITREQUEST, // stall
  input wire logic [31:0] AVS_WRITEDATA, // write data
  input wire logic [31:0] AVS_READDATA, // read data
  input wire logic NMI_IN, // non-maskable request
  input wire logic BRK_IN, // user break request
  input wire logic DBG_IN, // debug_interface request
  input wire logic [3:0] PIN_REQ, // request pins
  input wire logic [NSRC-1:0] SRC_REQ, // on-chip sources
  input wire logic [ivp_pkg::IVP_NETH-1:0] ETH_EVT, // eth events
  input wire logic [ivp_pkg::IVP_NLINK-1:0] LINK_EVT, // link events
  input wire logic REQ_VALID, // request to cpu
  input wire logic ETH_IRQ, // eth irq
  input wire logic [4:0] REQ_LEVEL, // winning level
  input wire logic [6:0] REQ_VECTOR, // winning vector
  input wire logic [31:0] REQ_ENTRY // table entry
);
  import ivp_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic [31:0] vb_r;
  // vector base mirror; limitation: assumes all byte lanes on writes
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      vb_r <= '0;
    end else if (CE && AVS_WRITE && AVS_ADDRESS == IVP_A_VBASE) begin
      vb_r <= AVS_WRITEDATA;
    end
  end
  AST_NMI_FIXED: assert property (CE && NMI_IN |=> REQ_VALID &&
    REQ_VECTOR == IVP_VEC_NMI && REQ_LEVEL == IVP_LVL_NMI)
    else $error("nmi map");
  AST_BRK_FIXED: assert property (CE && !NMI_IN && BRK_IN |=>
    REQ_VECTOR == IVP_VEC_BRK && REQ_LEVEL == IVP_LVL_FIX)
    else $error("brk map");
  AST_DBG_FIXED: assert property (CE && !NMI_IN && !BRK_IN && DBG_IN |=>
    REQ_VECTOR == IVP_VEC_DBG && REQ_LEVEL == IVP_LVL_FIX)
    else $error("dbg map");
  AST_ENTRY: assert property (REQ_VALID |->
    REQ_ENTRY == $past(vb_r) + {REQ_VECTOR, 2'b00}) else $error("bad entry");
  AST_LVL_NONZERO: assert property (REQ_VALID |-> REQ_LEVEL != 5'h00)
    else $error("level zero shown");
  AST_IDLE: assert property (CE && !NMI_IN && !BRK_IN && !DBG_IN &&
    PIN_REQ == 4'h0 && SRC_REQ == '0 && !ETH_IRQ |=> !REQ_VALID)
    else $error("request with no source");
  // words above the reserved slot (the write-only ack and the unmapped words) must read as zero
  AST_UNMAPPED_ZERO: assert property (AVS_READ && !AVS_WAITREQUEST &&
    AVS_ADDRESS > IVP_A_RSVB |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_ETH_CAUSE: assert property ($rose(ETH_IRQ) |->
    $past(|ETH_EVT || |LINK_EVT || AVS_WRITE) ||
    $past(|ETH_EVT || |LINK_EVT || AVS_WRITE, 2))
    else $error("eth irq uncaused");
  cover property (NMI_IN ##1 REQ_VALID);
  cover property ($rose(ETH_IRQ));
  cover property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > IVP_A_RSVB);
endmodule : ivp_top_properties

//--- sim/ivp_src_model.sv
// partner: peripheral source bank holding level requests until cleared
`timescale 1ns/1ps
module ivp_src_model #(
  parameter int N = 8
) (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic [N-1:0] set_m, // flags to raise
  input wire logic [N-1:0] clr_m, // flags to drop
  output logic [N-1:0] req // level requests
);
  // a flag stays up until its handler drops it, like a real peripheral
  always_ff @(posedge clk) begin
    if (rst) req <= '0;
    else req <= (req & ~clr_m) | set_m;
  end
endmodule : ivp_src_model

//--- sim/ivp_top_tb.sv
// testbench: register, mapping and interrupt checks of the vector map
`timescale 1ns/1ps
module ivp_top_tb;
  import ivp_pkg::*;
  logic CLOCK = 0, RST = 1, rd_s = 0, wr_s = 0, nmi = 0, brk = 0, dbg = 0;
  logic ext_en = 0, rvld, eirq, irq, wait_s, eth_p = 0;
  logic [5:0] adr = '0;
  logic [3:0] pin = '0;
  logic [6:0] ext_v = '0, rv;
  logic [4:0] rl;
  logic [1:0] sx = '0;
  logic [7:0] s_set = '0, s_clr = '0, src;
  logic [18:0] eev = '0;
  logic [2:0] lev = '0;
  logic [31:0] wd = '0, q, rn, rdata, entry, seed = 32'h0000_5c12;
  logic [31:0] ctrl = '0, pria = '0, prib = '0, veca = '0, vbase = '0;
  int err_total = 0, checks = 0, e;
  always #5 CLOCK = ~CLOCK;
  ivp_src_model #(.N(8)) i_src (.clk(CLOCK), .rst(RST), .set_m(s_set),
    .clr_m(s_clr), .req(src));
  ivp_top i_dut (.CLOCK(CLOCK), .RST(RST), .CE(1'b1), .AVS_ADDRESS(adr),
    .AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_s),
    .NMI_IN(nmi), .BRK_IN(brk), .DBG_IN(dbg), .PIN_REQ(pin),
    .EXT_VEC_EN(ext_en), .EXT_VEC(ext_v), .SRC_REQ(src), .ETH_EVT(eev),
    .LINK_EVT(lev), .REQ_VALID(rvld), .REQ_LEVEL(rl), .REQ_VECTOR(rv),
    .REQ_ENTRY(entry), .ETH_IRQ(eirq), .IRQ(irq));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // reference arbiter: strict greater keeps the lower index on ties
  function automatic int pick();
    int bl, bv, l, v;
    logic r;
    bl = 0;
    bv = 0;
    for (int i = 0; i < 10; i++) begin
      r = 0;
      l = 15;
      v = 64 + i - 3;
      case (i)
        0: begin
          r = nmi;
          l = 16;
          v = 11;
        end
        1: begin
          r = brk;
          v = 12;
        end
        2: begin
          r = dbg;
          v = 13;
        end
        7, 8: begin
          r = sx[i-7];
          l = prib[3:0];
          v = veca[64-8*i +: 7];
        end
        9: begin
          r = eth_p;
          l = prib[31:28];
          v = veca[30:24];
        end
        default: begin
          if (ctrl[0]) begin
            r = pin[i-3];
            l = pria[24-4*i +: 4];
          end else if (i == 3) begin
            r = pin != 0;
            l = pin;
            v = 64 + pin / 2;
          end
          if (ext_en) v = ext_v;
        end
      endcase
      if (r && l > bl) begin
        bl = l;
        bv = v;
      end
    end
    return bl * 128 + bv;
  endfunction : pick
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, x);
    end
  endtask : cmp
  // one bus cycle; request held until waitrequest is seen low, with no
  // cycle limit of its own: the watchdog ends a hung wait
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge CLOCK);
    adr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= !w;
    e = 0;
    @(posedge CLOCK);
    while (wait_s !== 1'b0) begin
      e++;
      @(posedge CLOCK);
    end
    q = rdata;
    wr_s <= 0;
    rd_s <= 0;
    #1;
    // writes answer at once, reads after one wait cycle
    cmp(e, w ? 0 : 1);
  endtask : bus
  task automatic chk_req();
    int m;
    m = pick();
    cmp(rvld, m > 127);
    if (m > 127) begin
      cmp({rl, rv}, m);
      cmp(entry, vbase + 4 * (m % 128));
    end
  endtask : chk_req
  task automatic ev(input logic [18:0] a, input logic [2:0] b);
    @(posedge CLOCK);
    eev <= a;
    lev <= b;
    @(posedge CLOCK);
    eev <= '0;
    lev <= '0;
    repeat (2) @(posedge CLOCK);
    #1;
  endtask : ev
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////////////
  // main sequence: reset, random mapping in both modes, eth and irq paths
  initial begin
    repeat (6) @(posedge CLOCK);
    RST <= 0;
    bus(0, IVP_A_CTRL, 0);
    cmp({q[0], rvld, eirq, irq}, 0);
    $display("test reset done");
    for (int t = 0; t < 240; t++) begin
      if (t % 40 == 0) begin
        ctrl = {31'h0, t >= 120};
        pria = xs();
        prib = xs();
        veca = xs();
        vbase = xs();
        bus(1, IVP_A_CTRL, ctrl);
        bus(1, IVP_A_PRIA, pria);
        bus(1, IVP_A_PRIB, prib);
        bus(1, IVP_A_VECA, veca);
        bus(1, IVP_A_VBASE, vbase);
      end
      rn = xs();
      @(posedge CLOCK);
      s_set <= {6'h0, rn[1:0]};
      s_clr <= {6'h0, ~rn[1:0]};
      sx = rn[1:0];
      @(posedge CLOCK);
      s_set <= '0;
      s_clr <= '0;
      nmi <= rn[31:28] == 0;
      brk <= rn[27:25] == 0;
      dbg <= rn[24:22] == 0;
      pin <= rn[7:4];
      ext_en <= rn[8];
      ext_v <= rn[15:9];
      @(posedge CLOCK);
      #1;
      chk_req();
    end
    $display("test mapping done");
    // an ack write while a request is shown sets status bit 0
    @(posedge CLOCK);
    nmi <= 1;
    brk <= 0;
    dbg <= 0;
    pin <= '0;
    s_clr <= 8'hff;
    sx = '0;
    bus(1, IVP_A_ACK, 0);
    bus(0, IVP_A_ISTAT, 0);
    cmp(q[0], 1);
    @(posedge CLOCK);
    nmi <= 0;
    bus(1, IVP_A_ETHEN, 32'h20);
    ev(19'h10, 0);
    cmp(eirq, 0);
    ev(19'h20, 0);
    cmp(eirq, 1);
    eth_p = 1;
    chk_req();
    bus(1, IVP_A_ETHST, 32'h20);
    eth_p = 0;
    cmp(eirq, 0);
    ctrl = 32'h2;
    bus(1, IVP_A_CTRL, ctrl);
    bus(1, IVP_A_ETHEN, 32'h8_0000);
    ev(0, 3'h4);
    cmp(eirq, 1);
    bus(0, IVP_A_ETHST, 0);
    cmp(q[IVP_ETH_COPY], 1);
    bus(1, IVP_A_IMASK, 2);
    cmp(irq, 1);
    bus(1, IVP_A_IMASK, 0);
    cmp(irq, 0);
    bus(1, IVP_A_ETHST, 32'h8_0000);
    bus(1, IVP_A_IMASK, 2);
    bus(0, IVP_A_ISTAT, 0);
    cmp(q[1], 1);
    cmp(irq, 0);
    // software keeps off the reserved slot; an unmapped word shows refusal
    bus(1, 6'h30, 32'hffff_ffff);
    bus(0, 6'h30, 0);
    cmp(q, 0);
    bus(0, 6'h3c, 0);
    cmp(q, 0);
    bus(0, IVP_A_VECA, 0);
    cmp(q & 32'h7f7f_7f7f, veca & 32'h7f7f_7f7f);
    $display("test eth and irq done");
    summarize();
  end
  // watchdog sized well past the fewer than nine hundred cycles the tests need
  initial begin
    #100000;
    err_total++;
    summarize();
  end
endmodule : ivp_top_tb
bind ivp_top ivp_top_properties #(.NSRC(NSRC)) i_prop (.CLOCK(CLOCK),
  .RST(RST), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .NMI_IN(NMI_IN), .BRK_IN(BRK_IN), .DBG_IN(DBG_IN), .PIN_REQ(PIN_REQ),
  .SRC_REQ(SRC_REQ), .ETH_EVT(ETH_EVT), .LINK_EVT(LINK_EVT),
  .REQ_VALID(REQ_VALID), .ETH_IRQ(ETH_IRQ), .REQ_LEVEL(REQ_LEVEL),
  .REQ_VECTOR(REQ_VECTOR), .REQ_ENTRY(REQ_ENTRY));
